// [logic/rx_error_count_pcs_config.sv]
// receive error counter and 100 Mb/s pcs configuration register bank
//
// Summary of operation
// - an errored symbol inside a valid carrier makes the count advance.
// - each carrier event advances the count once at most.
// - a carrier event that sees a collision is never counted.
// - the count sticks at 0xFF and a read returns it and clears it.
// - reserved upper bits of both registers read zero, writes ignored.
// - bit 10 set puts the 100 Mb/s transmitter in true quiet mode.
// - bit 9 set forces signal detect asserted in the pma.
// - bit 8 resets to one and picks enhanced (1) or reduced (0) detect.
// - bit 7 picks a 2 ms (1) or 722 us (0) descrambler sync timeout.
// - bit 5 set reports the 100 Mb/s link good whatever the monitor.
// - bit 2 set takes nrzi coding out of the data path.
// - a half-full count latches a status flag that can interrupt.
`timescale 1ns/100ps
`include "rxerr_pcs_regs.svh"
module rx_error_count_pcs_config #(
    parameter logic [15:0] DESC_LONG_CYCLES =
        16'(`DESC_LONG_NS / `CLK_PERIOD_NS),
    parameter logic [15:0] DESC_SHORT_CYCLES =
        16'(`DESC_SHORT_NS / `CLK_PERIOD_NS)
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire rxerr_pcs_pkg::reg_addr_t REG_ADDR,
    input wire rxerr_pcs_pkg::reg_data_t REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output rxerr_pcs_pkg::reg_data_t REG_RDATA,
    input wire logic RX_CARRIER,
    input wire logic RX_SYMBOL_ERR,
    input wire logic RX_COLLISION,
    input wire logic LINK_MONITOR_OK,
    input wire logic DESC_IDLE_SEEN,
    output logic TX_TRUE_QUIET,
    output logic SD_FORCE,
    output logic SD_ENHANCED,
    output logic DESC_SYNC_LOST,
    output logic LINK_100_GOOD,
    output logic NRZI_BYPASS,
    output logic IRQ
);
    import rxerr_pcs_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    // async assert, release through two flops
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg_data_t pcs_reg;
    reg_data_t pcs_next;
    reg_data_t rdata_reg;
    reg_data_t rdata_next;
    logic flag_reg;
    logic flag_next;
    logic mask_reg;
    logic mask_next;
    logic irq_reg;
    logic link_good_reg;
    logic [15:0] desc_tmr_reg;
    logic [15:0] desc_tmr_next;
    logic [15:0] desc_limit;
    logic desc_lost_reg;
    logic desc_lost_next;
    logic desc_expire;
    logic sel_status;
    logic sel_count;
    logic sel_pcs;
    logic sel_mask;
    logic rd_status;
    logic wr_status;
    logic wr_pcs;
    logic wr_mask;

    err_count_if ec ();

    // ------------------------------------------------------------
    // error counter
    // ------------------------------------------------------------
    // event inputs go to the counter; reading the count clears it
    assign ec.carrier = RX_CARRIER;
    assign ec.sym_err = RX_SYMBOL_ERR;
    assign ec.collision = RX_COLLISION;
    assign ec.clear = REG_RD && sel_count;

    rx_error_event_counter rx_error_event_counter_inst (
        .clk(CLK),
        .rst_n(rst_n),
        .ec(ec)
    );

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // unmapped addresses read zero and ignore writes
    assign sel_status = (REG_ADDR == `REG_INT_STATUS);
    assign sel_count = (REG_ADDR == `REG_RX_ERR_COUNT);
    assign sel_pcs = (REG_ADDR == `REG_PCS_CFG);
    assign sel_mask = (REG_ADDR == `REG_INT_MASK);
    assign rd_status = REG_RD && sel_status;
    assign wr_status = REG_WR && sel_status;
    assign wr_pcs = REG_WR && sel_pcs;
    assign wr_mask = REG_WR && sel_mask;

    // ------------------------------------------------------------
    // pcs configuration register
    // ------------------------------------------------------------
    // only the documented control bits take a write
    assign pcs_next = wr_pcs ?
        (REG_WDATA & `PCS_CFG_WR_MASK) : pcs_reg;

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    // set wins over read-clear and over write-one-clear
    assign flag_next = ec.half_full ||
        (flag_reg && !rd_status &&
         !(wr_status && REG_WDATA[`INT_HALF_FULL_BIT]));
    assign mask_next = wr_mask ? REG_WDATA[`INT_HALF_FULL_BIT] :
        mask_reg;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_next = 16'h0000;
        if (REG_RD && sel_count) begin
            rdata_next = {8'h00, ec.count};
        end else if (REG_RD && sel_pcs) begin
            rdata_next = pcs_reg;
        end else if (rd_status) begin
            rdata_next[`INT_HALF_FULL_BIT] = flag_reg;
        end else if (REG_RD && sel_mask) begin
            rdata_next[`INT_HALF_FULL_BIT] = mask_reg;
        end
    end

    // ------------------------------------------------------------
    // descrambler sync timer
    // ------------------------------------------------------------
    // idle symbols restart the timer; expiry holds until idle returns
    assign desc_limit = pcs_reg[`PCS_DESC_LONG_BIT] ?
        DESC_LONG_CYCLES : DESC_SHORT_CYCLES;
    assign desc_expire = (desc_tmr_reg >= desc_limit - 16'h0001);
    assign desc_tmr_next = DESC_IDLE_SEEN ? 16'h0000 :
        desc_expire ? desc_tmr_reg : desc_tmr_reg + 16'h0001;
    assign desc_lost_next = !DESC_IDLE_SEEN &&
        (desc_lost_reg || desc_expire);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pcs_reg <= `PCS_CFG_RESET;
            rdata_reg <= 16'h0000;
            flag_reg <= 1'b0;
            mask_reg <= 1'b0;
        end else begin
            pcs_reg <= pcs_next;
            rdata_reg <= rdata_next;
            flag_reg <= flag_next;
            mask_reg <= mask_next;
        end
    end

    // link report, interrupt line and timer
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            link_good_reg <= 1'b0;
            irq_reg <= 1'b0;
            desc_tmr_reg <= 16'h0000;
            desc_lost_reg <= 1'b0;
        end else begin
            link_good_reg <= pcs_reg[`PCS_LINK_OVR_BIT] ||
                LINK_MONITOR_OK;
            irq_reg <= flag_reg && mask_reg;
            desc_tmr_reg <= desc_tmr_next;
            desc_lost_reg <= desc_lost_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign REG_RDATA = rdata_reg;
    assign TX_TRUE_QUIET = pcs_reg[`PCS_QUIET_BIT];
    assign SD_FORCE = pcs_reg[`PCS_SD_OVR_BIT];
    assign SD_ENHANCED = pcs_reg[`PCS_SD_ALG_BIT];
    assign NRZI_BYPASS = pcs_reg[`PCS_NRZI_BYP_BIT];
    assign LINK_100_GOOD = link_good_reg;
    assign DESC_SYNC_LOST = desc_lost_reg;
    assign IRQ = irq_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_count_rsv;
        @(posedge CLK) disable iff (!rst_n)
        REG_RD && sel_count |=> REG_RDATA[15:8] == 8'h00;
    endproperty
    a_count_rsv: assert property (p_count_rsv)
        else $error("counter reserved bits read nonzero");

    property p_pcs_rsv;
        @(posedge CLK) disable iff (!rst_n)
        REG_RD && sel_pcs |=> REG_RDATA[15:11] == 5'h00 &&
            REG_RDATA[6] == 1'b0 && REG_RDATA[4:3] == 2'h0 &&
            REG_RDATA[1:0] == 2'h0;
    endproperty
    a_pcs_rsv: assert property (p_pcs_rsv)
        else $error("pcs reserved bits read nonzero");

    property p_read_count;
        @(posedge CLK) disable iff (!rst_n)
        REG_RD && sel_count |=> REG_RDATA[7:0] == $past(ec.count) &&
            ec.count <= 8'h01;
    endproperty
    a_read_count: assert property (p_read_count)
        else $error("count read did not return and clear");

    property p_quiet;
        @(posedge CLK) disable iff (!rst_n)
        wr_pcs |=> TX_TRUE_QUIET == $past(REG_WDATA[`PCS_QUIET_BIT]);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("quiet transmit not following write");

    property p_sd_force;
        @(posedge CLK) disable iff (!rst_n)
        wr_pcs |=> SD_FORCE == $past(REG_WDATA[`PCS_SD_OVR_BIT]);
    endproperty
    a_sd_force: assert property (p_sd_force)
        else $error("signal detect override not following write");

    property p_sd_alg;
        @(posedge CLK)
        $rose(rst_n) |-> SD_ENHANCED;
    endproperty
    a_sd_alg: assert property (p_sd_alg)
        else $error("detect algorithm not enhanced after reset");

    property p_nrzi;
        @(posedge CLK) disable iff (!rst_n)
        wr_pcs |=> NRZI_BYPASS == $past(REG_WDATA[`PCS_NRZI_BYP_BIT]);
    endproperty
    a_nrzi: assert property (p_nrzi)
        else $error("nrzi bypass not following write");

    property p_desc_bound;
        @(posedge CLK) disable iff (!rst_n)
        !DESC_IDLE_SEEN && desc_expire |=> DESC_SYNC_LOST;
    endproperty
    a_desc_bound: assert property (p_desc_bound)
        else $error("descrambler timeout not flagged");

    property p_desc_idle;
        @(posedge CLK) disable iff (!rst_n)
        DESC_IDLE_SEEN |=> !DESC_SYNC_LOST && desc_tmr_reg == 16'h0000;
    endproperty
    a_desc_idle: assert property (p_desc_idle)
        else $error("idle did not restart descrambler timer");

    property p_link;
        @(posedge CLK) disable iff (!rst_n)
        pcs_reg[`PCS_LINK_OVR_BIT] |=> LINK_100_GOOD;
    endproperty
    a_link: assert property (p_link)
        else $error("forced link not reported good");

    sequence s_half_event;
        ec.half_full ##1 flag_reg;
    endsequence
    property p_half_irq;
        @(posedge CLK) disable iff (!rst_n)
        ec.half_full && mask_reg && !wr_mask |-> s_half_event ##1 IRQ;
    endproperty
    a_half_irq: assert property (p_half_irq)
        else $error("half-full event did not interrupt");

    property p_reset_vals;
        @(posedge CLK)
        $rose(rst_n) |-> pcs_reg == `PCS_CFG_RESET && ec.count == 8'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset defaults not loaded");
endmodule : rx_error_count_pcs_config

// [logic/rxerr_pcs_regs.svh]
// register offsets, fields, reset values and timing constants
`ifndef RXERR_PCS_REGS_SVH
`define RXERR_PCS_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_INT_STATUS 8'h12
`define REG_RX_ERR_COUNT 8'h15
`define REG_PCS_CFG 8'h16
`define REG_INT_MASK 8'h1B

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCS_QUIET_BIT 10
`define PCS_SD_OVR_BIT 9
`define PCS_SD_ALG_BIT 8
`define PCS_DESC_LONG_BIT 7
`define PCS_LINK_OVR_BIT 5
`define PCS_NRZI_BYP_BIT 2
`define INT_HALF_FULL_BIT 8

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define PCS_CFG_RESET 16'h0100
`define PCS_CFG_WR_MASK 16'h07A4
`define ERR_COUNT_RESET 8'h00
`define ERR_COUNT_MAX 8'hFF
`define ERR_COUNT_BELOW_HALF 8'h7F

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define DESC_LONG_NS 2000000
`define DESC_SHORT_NS 722000

`endif

// [logic/rxerr_pcs_pkg.sv]
// types shared by the error counter and the pcs configuration block
package rxerr_pcs_pkg;
    typedef logic [7:0] reg_addr_t;
    typedef logic [15:0] reg_data_t;
    typedef logic [7:0] err_count_t;

    // carrier event tracking, gray coded along idle-carrier-errored
    typedef enum logic [1:0] {
        EV_IDLE = 2'b00,
        EV_CARRIER = 2'b01,
        EV_ERRORED = 2'b11,
        EV_COLLIDED = 2'b10
    } ev_state_t;
endpackage : rxerr_pcs_pkg

// [logic/err_count_if.sv]
// signals between the register bank and the receive error counter
`timescale 1ns/100ps
interface err_count_if;
    import rxerr_pcs_pkg::*;
    logic carrier;
    logic sym_err;
    logic collision;
    logic clear;
    err_count_t count;
    logic half_full;

    modport counter (
        input carrier,
        input sym_err,
        input collision,
        input clear,
        output count,
        output half_full
    );
    modport bank (
        output carrier,
        output sym_err,
        output collision,
        output clear,
        input count,
        input half_full
    );
endinterface : err_count_if

// [logic/rx_error_event_counter.sv]
// saturating clear-on-read receive symbol error counter
`timescale 1ns/100ps
module rx_error_event_counter (
    input wire logic clk,
    input wire logic rst_n,
    err_count_if.counter ec
);
    import rxerr_pcs_pkg::*;
    `include "rxerr_pcs_regs.svh"

    ev_state_t ev_state_reg;
    ev_state_t ev_state_next;
    err_count_t count_reg;
    err_count_t count_next;
    logic half_full_reg;
    logic bump;
    logic saturated;

    // ------------------------------------------------------------
    // carrier event tracking
    // ------------------------------------------------------------
    always_comb begin
        ev_state_next = ev_state_reg;
        unique case (ev_state_reg)
            EV_IDLE: begin
                if (ec.carrier && ec.collision) begin
                    ev_state_next = EV_COLLIDED;
                end else if (ec.carrier && ec.sym_err) begin
                    ev_state_next = EV_ERRORED;
                end else if (ec.carrier) begin
                    ev_state_next = EV_CARRIER;
                end
            end
            EV_CARRIER: begin
                if (!ec.carrier) begin
                    ev_state_next = EV_IDLE;
                end else if (ec.collision) begin
                    ev_state_next = EV_COLLIDED;
                end else if (ec.sym_err) begin
                    ev_state_next = EV_ERRORED;
                end
            end
            EV_ERRORED: begin
                if (!ec.carrier) begin
                    ev_state_next = EV_IDLE;
                end else if (ec.collision) begin
                    ev_state_next = EV_COLLIDED;
                end
            end
            EV_COLLIDED: begin
                if (!ec.carrier) begin
                    ev_state_next = EV_IDLE;
                end
            end
        endcase
    end

    // one count per errored event, taken when the carrier drops
    assign bump = (ev_state_reg == EV_ERRORED) && !ec.carrier;
    assign saturated = (count_reg == `ERR_COUNT_MAX);

    // read clears, but an event in the same cycle still counts
    assign count_next = ec.clear ? {7'h00, bump} :
        (bump && !saturated) ? count_reg + 8'h01 : count_reg;

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_state_reg <= EV_IDLE;
            count_reg <= `ERR_COUNT_RESET;
            half_full_reg <= 1'b0;
        end else begin
            ev_state_reg <= ev_state_next;
            count_reg <= count_next;
            half_full_reg <= (count_reg == `ERR_COUNT_BELOW_HALF) &&
                bump && !ec.clear;
        end
    end

    assign ec.count = count_reg;
    assign ec.half_full = half_full_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_err_end;
        ev_state_reg == EV_ERRORED && !ec.carrier;
    endsequence
    sequence s_col_end;
        ev_state_reg == EV_COLLIDED && !ec.carrier;
    endsequence

    property p_count_event;
        @(posedge clk) disable iff (!rst_n)
        s_err_end and (!ec.clear && !saturated) |=>
            count_reg == $past(count_reg) + 8'h01;
    endproperty
    a_count_event: assert property (p_count_event)
        else $error("errored carrier event not counted");

    property p_once;
        @(posedge clk) disable iff (!rst_n)
        !bump |=> count_reg == $past(count_reg) || count_reg == 8'h00;
    endproperty
    a_once: assert property (p_once)
        else $error("count moved outside an event end");

    property p_no_col;
        @(posedge clk) disable iff (!rst_n)
        s_col_end |=> count_reg <= $past(count_reg);
    endproperty
    a_no_col: assert property (p_no_col)
        else $error("collided event was counted");

    property p_saturate;
        @(posedge clk) disable iff (!rst_n)
        saturated && !ec.clear |=> saturated;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("error count wrapped");
endmodule : rx_error_event_counter

// [sim/mgmt_master.sv]
// management station model driving the register port
`timescale 1ns/100ps
`include "rxerr_pcs_regs.svh"
module mgmt_master (
    input wire logic CLK,
    output rxerr_pcs_pkg::reg_addr_t REG_ADDR,
    output rxerr_pcs_pkg::reg_data_t REG_WDATA,
    output logic REG_WR,
    output logic REG_RD,
    input wire rxerr_pcs_pkg::reg_data_t REG_RDATA
);
    import rxerr_pcs_pkg::*;

    // must-be-zero bits 12:11, 6, 4:3 and 1:0 of the pcs configuration register
    localparam reg_data_t MBZ_MASK = 16'h185B;

    // bus idle at time zero
    initial begin
        REG_ADDR = 8'h00;
        REG_WDATA = 16'h0000;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
    end

    // one-cycle write; data lines scrambled once released
    task automatic write_reg(input reg_addr_t addr, input reg_data_t data);
        reg_data_t val;
        val = data;
        if (addr == `REG_PCS_CFG) begin
            val = data & ~MBZ_MASK;
        end
        @(posedge CLK);
        REG_ADDR <= addr;
        REG_WDATA <= val;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
        REG_WDATA <= ~val;
    endtask : write_reg

    // one-cycle read; data taken in the cycle after the strobe
    task automatic read_reg(input reg_addr_t addr, output reg_data_t data);
        @(posedge CLK);
        REG_ADDR <= addr;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        data = REG_RDATA;
    endtask : read_reg
endmodule : mgmt_master

// [sim/test_rx_error_count_pcs_config.sv]
// self-checking bench for the error counter and pcs configuration bank
`timescale 1ns/100ps
`include "rxerr_pcs_regs.svh"
module test_rx_error_count_pcs_config;
    import rxerr_pcs_pkg::*;

    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    reg_addr_t REG_ADDR;
    reg_data_t REG_WDATA;
    logic REG_WR;
    logic REG_RD;
    reg_data_t REG_RDATA;
    logic RX_CARRIER = 1'b0;
    logic RX_SYMBOL_ERR = 1'b0;
    logic RX_COLLISION = 1'b0;
    logic LINK_MONITOR_OK = 1'b0;
    logic DESC_IDLE_SEEN = 1'b0;
    logic TX_TRUE_QUIET, SD_FORCE, SD_ENHANCED, DESC_SYNC_LOST;
    logic LINK_100_GOOD, NRZI_BYPASS, IRQ;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    reg_data_t rd;
    int cfg_bits[6] = '{10, 9, 8, 7, 5, 2};
    reg_data_t cfg_outs_exp[6] = '{16'h8, 16'h4, 16'h2, 16'h0, 16'h0, 16'h1};
    wire reg_data_t cfg_outs = {12'h000, TX_TRUE_QUIET, SD_FORCE,
        SD_ENHANCED, NRZI_BYPASS};
    // watched outputs, read by wait_chk only after its wait
    wire logic [2:0] mon = {IRQ, LINK_100_GOOD, DESC_SYNC_LOST};
    localparam int SEL_LOST = 0;
    localparam int SEL_LINK = 1;
    localparam int SEL_IRQ = 2;

    // 20 MHz clock
    always #25 CLK = ~CLK;

    rx_error_count_pcs_config #(
        .DESC_LONG_CYCLES(16'h0028),
        .DESC_SHORT_CYCLES(16'h0014)
    ) rx_error_count_pcs_config_inst (
        .CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .RX_CARRIER(RX_CARRIER),
        .RX_SYMBOL_ERR(RX_SYMBOL_ERR), .RX_COLLISION(RX_COLLISION),
        .LINK_MONITOR_OK(LINK_MONITOR_OK), .DESC_IDLE_SEEN(DESC_IDLE_SEEN),
        .TX_TRUE_QUIET(TX_TRUE_QUIET), .SD_FORCE(SD_FORCE),
        .SD_ENHANCED(SD_ENHANCED), .DESC_SYNC_LOST(DESC_SYNC_LOST),
        .LINK_100_GOOD(LINK_100_GOOD), .NRZI_BYPASS(NRZI_BYPASS), .IRQ(IRQ)
    );

    mgmt_master mgmt_master_inst (
        .CLK(CLK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input reg_data_t seen, input reg_data_t exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic rd_chk(input reg_addr_t a, input reg_data_t exp);
        mgmt_master_inst.read_reg(a, rd);
        check(rd, exp);
    endtask : rd_chk

    // one carrier event, errors over two cycles, optional collision
    task automatic rx_event(input logic err, input logic col);
        @(posedge CLK);
        RX_CARRIER <= 1'b1;
        RX_COLLISION <= col;
        @(posedge CLK);
        RX_SYMBOL_ERR <= err;
        repeat (2) @(posedge CLK);
        RX_SYMBOL_ERR <= 1'b0;
        RX_CARRIER <= 1'b0;
        RX_COLLISION <= 1'b0;
        repeat (2) @(posedge CLK);
    endtask : rx_event

    task automatic wait_chk(input int n, input int sel, input logic exp);
        repeat (n) @(posedge CLK);
        #1;
        check(16'(mon[sel]), 16'(exp));
    endtask : wait_chk

    // hang guard
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 12000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge CLK);
        ARST_N <= 1'b1;
        repeat (4) @(posedge CLK);
        rd_chk(`REG_RX_ERR_COUNT, 16'h0000);
        rd_chk(`REG_PCS_CFG, 16'h0100);
        check(cfg_outs, 16'h0002);
        // stray errors without carrier, then one errored event
        @(posedge CLK);
        RX_SYMBOL_ERR <= 1'b1;
        repeat (2) @(posedge CLK);
        RX_SYMBOL_ERR <= 1'b0;
        rx_event(1'b1, 1'b0);
        rd_chk(`REG_RX_ERR_COUNT, 16'h0001);
        rd_chk(`REG_RX_ERR_COUNT, 16'h0000);
        rx_event(1'b1, 1'b1);
        rx_event(1'b0, 1'b0);
        rd_chk(`REG_RX_ERR_COUNT, 16'h0000);
        // reserved bits and unmapped place
        mgmt_master_inst.write_reg(`REG_RX_ERR_COUNT, 16'hFFFF);
        rd_chk(`REG_RX_ERR_COUNT, 16'h0000);
        mgmt_master_inst.write_reg(`REG_PCS_CFG, 16'hFFFF);
        rd_chk(`REG_PCS_CFG, 16'h07A4);
        check(cfg_outs, 16'h000F);
        rd_chk(8'h13, 16'h0000);
        // each control bit alone
        foreach (cfg_bits[i]) begin
            mgmt_master_inst.write_reg(`REG_PCS_CFG, 16'h0001 << cfg_bits[i]);
            rd_chk(`REG_PCS_CFG, 16'h0001 << cfg_bits[i]);
            check(cfg_outs, cfg_outs_exp[i]);
        end
        // descrambler timeout, short then long
        mgmt_master_inst.write_reg(`REG_PCS_CFG, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            @(posedge CLK);
            DESC_IDLE_SEEN <= 1'b1;
            @(posedge CLK);
            DESC_IDLE_SEEN <= 1'b0;
            wait_chk(15 + 15 * k, SEL_LOST, 1'b0);
            wait_chk(10 + 5 * k, SEL_LOST, 1'b1);
            mgmt_master_inst.write_reg(`REG_PCS_CFG, 16'h0080);
        end
        // link good from monitor or override
        mgmt_master_inst.write_reg(`REG_PCS_CFG, 16'h0000);
        wait_chk(2, SEL_LINK, 1'b0);
        @(posedge CLK);
        LINK_MONITOR_OK <= 1'b1;
        wait_chk(3, SEL_LINK, 1'b1);
        @(posedge CLK);
        LINK_MONITOR_OK <= 1'b0;
        wait_chk(3, SEL_LINK, 1'b0);
        mgmt_master_inst.write_reg(`REG_PCS_CFG, 16'h0020);
        wait_chk(3, SEL_LINK, 1'b1);
        // half-full flag, mask, clear on read, saturation
        mgmt_master_inst.write_reg(`REG_INT_MASK, 16'h0100);
        repeat (127) rx_event(1'b1, 1'b0);
        wait_chk(3, SEL_IRQ, 1'b0);
        rx_event(1'b1, 1'b0);
        wait_chk(3, SEL_IRQ, 1'b1);
        mgmt_master_inst.write_reg(`REG_INT_MASK, 16'h0000);
        wait_chk(2, SEL_IRQ, 1'b0);
        rd_chk(`REG_INT_STATUS, 16'h0100);
        mgmt_master_inst.write_reg(`REG_INT_MASK, 16'h0100);
        wait_chk(2, SEL_IRQ, 1'b0);
        repeat (140) rx_event(1'b1, 1'b0);
        rd_chk(`REG_RX_ERR_COUNT, 16'h00FF);
        rd_chk(`REG_RX_ERR_COUNT, 16'h0000);
        wait_chk(1, SEL_IRQ, 1'b0);
        repeat (128) rx_event(1'b1, 1'b0);
        wait_chk(3, SEL_IRQ, 1'b1);
        mgmt_master_inst.write_reg(`REG_INT_STATUS, 16'h0100);
        wait_chk(2, SEL_IRQ, 1'b0);
        rd_chk(`REG_INT_MASK, 16'h0100);
        end_of_test();
    end
endmodule : test_rx_error_count_pcs_config
